// >>> ctue_pkg.sv
// Purpose: Shared constants for the contact timecode user-bit encoder
// Assumes: APB register map with one 32-bit word per register
// Notes: Line numbers are absolute video line numbers
package ctue_pkg;
  // Register byte offsets
  localparam logic [7:0] CTUE_CTRL_OFS = 8'h00;
  localparam logic [7:0] CTUE_DELAY_OFS = 8'h04;
  localparam logic [7:0] CTUE_GEN_OFS = 8'h08;
  localparam logic [7:0] CTUE_RDR_OFS = 8'h0C;
  localparam logic [7:0] CTUE_STAT_OFS = 8'h10;
  // Control fields
  localparam int CTUE_MODE_BIT = 0;
  localparam int CTUE_STD_LSB = 4;
  localparam int CTUE_STD_W = 5;
  // Line setting field positions (first in low byte, second at bit 8)
  localparam int CTUE_LN_W = 6;
  localparam int CTUE_LN2_LSB = 8;
  // Delay
  localparam int CTUE_DLY_W = 10;
  localparam logic [9:0] CTUE_DLY_RST = 10'h000;
  // Line ranges and defaults
  localparam logic [5:0] CTUE_LN_MIN_525 = 6'h0A;
  localparam logic [5:0] CTUE_LN_MIN_625 = 6'h06;
  localparam logic [5:0] CTUE_LN_MAX = 6'h20;
  localparam logic [5:0] CTUE_GEN1_525 = 6'h0E;
  localparam logic [5:0] CTUE_GEN2_525 = 6'h10;
  localparam logic [5:0] CTUE_GEN1_625 = 6'h13;
  localparam logic [5:0] CTUE_GEN2_625 = 6'h15;
  localparam logic [5:0] CTUE_RDS_525 = 6'h0A;
  localparam logic [5:0] CTUE_RDE_525 = 6'h14;
  localparam logic [5:0] CTUE_RDS_625 = 6'h06;
  localparam logic [5:0] CTUE_RDE_625 = 6'h15;
  // Contact codes, first user-bit data byte
  localparam int CTUE_NCONT = 6;
  localparam logic [7:0] CTUE_CODE_BASE = 8'h80;
  // Deferred code: kind field in byte 1 bits 1:0, zero means immediate pattern
  localparam logic [1:0] CTUE_KIND_IMM = 2'h0;
  localparam logic [1:0] CTUE_KIND_ANN = 2'h1;
  localparam logic [1:0] CTUE_KIND_ACT = 2'h2;
  // Video standards
  typedef enum logic [4:0] {
    CTUE_STD_AUTO, CTUE_STD_1035_60, CTUE_STD_1035_59, CTUE_STD_1P30,
    CTUE_STD_1P29, CTUE_STD_1P25, CTUE_STD_1P24, CTUE_STD_1P23,
    CTUE_STD_720_60, CTUE_STD_720_59, CTUE_STD_1I60, CTUE_STD_1I59,
    CTUE_STD_1I50, CTUE_STD_1S24, CTUE_STD_1S23, CTUE_STD_525,
    CTUE_STD_625
  } ctue_std_t;
endpackage : ctue_pkg

// >>> ctue_line_clamp.sv
// Purpose: Clamp a written line number into the range of the standard
// Assumes: Combinational helper
// Notes: Used for every line setting
`timescale 1ns/1ps
module ctue_line_clamp (
  input wire logic [5:0] line_in,
  input wire logic is_625,
  output logic [5:0] line_out
);
  logic [5:0] lo;
  always_comb begin
    lo = is_625 ? ctue_pkg::CTUE_LN_MIN_625 : ctue_pkg::CTUE_LN_MIN_525;
    if (line_in < lo) begin
      line_out = lo;
    end else if (line_in > ctue_pkg::CTUE_LN_MAX) begin
      line_out = ctue_pkg::CTUE_LN_MAX;
    end else begin
      line_out = line_in;
    end
  end
endmodule : ctue_line_clamp

// >>> ctue_defer_slot.sv
// Purpose: Frame countdown for one contact input in deferred mode
// Assumes: frame_pulse is one cycle per frame
// Notes: Arms on a rising contact, fires once the delay has elapsed
`timescale 1ns/1ps
module ctue_defer_slot #(
  parameter int DW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_pulse,
  input wire logic start,
  input wire logic [DW-1:0] delay,
  output logic busy,
  output logic fire
);
  typedef struct packed {
    logic busy;
    logic [DW-1:0] cnt;
  } ctue_slot_t;
  ctue_slot_t s_q, s_d;
  // Fire is due on the frame itself, so the act code lands exactly delay
  // frames after the announce, when the decoder countdown runs out
  always_comb begin
    s_d = s_q;
    fire = 1'b0;
    if (start && !s_q.busy) begin
      if (delay == '0) begin
        fire = 1'b1;
      end else begin
        s_d.busy = 1'b1;
        s_d.cnt = delay;
      end
    end else if (s_q.busy && frame_pulse) begin
      if (s_q.cnt <= DW'(1)) begin
        s_d.busy = 1'b0;
        fire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign busy = s_q.busy;
endmodule : ctue_defer_slot

// >>> ctue_encoder.sv
// Purpose: Contact-closure to timecode user-bit encoder with APB registers
// Assumes: Frame and line strobes and timecode words from the video path
// Notes: Timecode words are 64-bit: time bits and four user-bit bytes
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module ctue_encoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] contact_input_n,
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic [5:0] line_number,
  input wire logic [4:0] detected_standard,
  input wire logic tc_in_valid,
  input wire logic [63:0] tc_in,
  output logic [63:0] tc_out,
  output logic tc_out_valid,
  output logic tc_out_is_atc
);
  localparam int NC = ctue_pkg::CTUE_NCONT;
  localparam int DW = ctue_pkg::CTUE_DLY_W;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic deferred;
    ctue_pkg::ctue_std_t std_sel;
    logic [DW-1:0] delay;
    logic [5:0] gen1;
    logic [5:0] gen2;
    logic [5:0] rd_start;
    logic [5:0] rd_end;
    logic tc_seen;
    logic tc_seen_frame;
    logic [NC-1:0] prev;
    logic [7:0] ann_bits;
    logic [7:0] act_bits;
    logic [31:0] gen_time;
    logic [63:0] tc_out;
    logic tc_out_valid;
    logic tc_out_is_atc;
    logic last_625;
  } ctue_state_t;
  ctue_state_t s_q, s_d;

  logic [NC-1:0] closed;
  logic [NC-1:0] start_vec;
  logic [NC-1:0] busy_vec;
  logic [NC-1:0] fire_vec;
  logic [5:0] gen1_c, gen2_c, rds_c, rde_c;
  ctue_pkg::ctue_std_t eff_std;
  logic is_sd, is_625;
  logic [7:0] addr8;

  assign closed = ~contact_input_n;
  // Upper address bits set fold onto an unmapped offset
  assign addr8 = (paddr[31:8] == 24'h0) ? paddr[7:0] : 8'hFF;
  // Auto follows the detector; a forced value overrides it
  assign eff_std = (s_q.std_sel == ctue_pkg::CTUE_STD_AUTO) ?
    ctue_pkg::ctue_std_t'(detected_standard) : s_q.std_sel;
  assign is_625 = eff_std == ctue_pkg::CTUE_STD_625;
  assign is_sd = is_625 || eff_std == ctue_pkg::CTUE_STD_525;

  // Deferred slot arms on the frame a contact first closes
  assign start_vec = s_q.deferred ? (closed & ~s_q.prev) & {NC{frame_pulse}}
                                  : '0;

  for (genvar i = 0; i < NC; i++) begin : g_slot
    ctue_defer_slot #(.DW(DW)) u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .frame_pulse(frame_pulse),
      .start(start_vec[i]),
      .delay(s_q.delay),
      .busy(busy_vec[i]),
      .fire(fire_vec[i])
    );
  end

  ctue_line_clamp u_cl_g1 (.line_in(pwdata[5:0]), .is_625(is_625),
    .line_out(gen1_c));
  ctue_line_clamp u_cl_g2 (.line_in(pwdata[13:8]), .is_625(is_625),
    .line_out(gen2_c));
  ctue_line_clamp u_cl_rs (.line_in(pwdata[5:0]), .is_625(is_625),
    .line_out(rds_c));
  ctue_line_clamp u_cl_re (.line_in(pwdata[13:8]), .is_625(is_625),
    .line_out(rde_c));

  function automatic logic [7:0] code_of(input logic [NC-1:0] v);
    // Bit n of the byte flags input n+1, top bit marks a contact code
    code_of = (v == '0) ? 8'h00 : (ctue_pkg::CTUE_CODE_BASE | {2'b00, v});
  endfunction : code_of

  logic [7:0] imm_byte;
  logic [7:0] ann_now, act_now;
  logic [31:0] ubits;
  logic in_gen_line, in_rd_window;
  logic wr_acc, rd_acc;

  always_comb begin
    // Held contacts OR together so none is dropped
    imm_byte = code_of(closed);
    ann_now = frame_pulse ? code_of(start_vec) : s_q.ann_bits;
    act_now = frame_pulse ? code_of(fire_vec) : s_q.act_bits;
    ubits = '0;
    if (!s_q.deferred) begin
      ubits[7:0] = imm_byte;
      ubits[9:8] = ctue_pkg::CTUE_KIND_IMM;
    end else if (act_now != 8'h00) begin
      ubits[7:0] = act_now;
      ubits[9:8] = ctue_pkg::CTUE_KIND_ACT;
    end else if (ann_now != 8'h00) begin
      // Announce carries which inputs and the delay in frames
      ubits[7:0] = ann_now;
      ubits[9:8] = ctue_pkg::CTUE_KIND_ANN;
      ubits[25:16] = s_q.delay;
    end
    // Single line when both settings match is automatic here
    in_gen_line = line_pulse && (line_number == s_q.gen1 ||
                                 line_number == s_q.gen2);
    in_rd_window = line_pulse && line_number >= s_q.rd_start &&
                   line_number <= s_q.rd_end;
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.tc_out_valid = 1'b0;
    s_d.last_625 = is_625;
    // Reload the per-standard defaults when the SD standard changes
    if (is_625 != s_q.last_625) begin
      s_d.gen1 = is_625 ? ctue_pkg::CTUE_GEN1_625 : ctue_pkg::CTUE_GEN1_525;
      s_d.gen2 = is_625 ? ctue_pkg::CTUE_GEN2_625 : ctue_pkg::CTUE_GEN2_525;
      s_d.rd_start = is_625 ? ctue_pkg::CTUE_RDS_625
                            : ctue_pkg::CTUE_RDS_525;
      s_d.rd_end = is_625 ? ctue_pkg::CTUE_RDE_625 : ctue_pkg::CTUE_RDE_525;
    end
    if (psel && penable && !s_q.pready) begin
      if (wr_acc || rd_acc) begin
        unique case (addr8)
          ctue_pkg::CTUE_CTRL_OFS: begin
            if (pwrite) begin
              s_d.deferred = pwdata[ctue_pkg::CTUE_MODE_BIT];
              s_d.std_sel = ctue_pkg::ctue_std_t'(pwdata[
                ctue_pkg::CTUE_STD_LSB +: ctue_pkg::CTUE_STD_W]);
            end
          end
          ctue_pkg::CTUE_DELAY_OFS: begin
            if (pwrite) begin
              s_d.delay = pwdata[DW-1:0];
            end
          end
          ctue_pkg::CTUE_GEN_OFS: begin
            if (pwrite) begin
              s_d.gen1 = gen1_c;
              s_d.gen2 = gen2_c;
            end
          end
          ctue_pkg::CTUE_RDR_OFS: begin
            if (pwrite) begin
              s_d.rd_start = rds_c;
              // End follows start upward rather than inverting
              s_d.rd_end = (rds_c > rde_c) ? rds_c : rde_c;
            end
          end
          ctue_pkg::CTUE_STAT_OFS: begin
            s_d.pslverr = pwrite;
          end
          default: begin
            s_d.pslverr = 1'b1;
          end
        endcase
      end
      if (!pwrite) begin
        unique case (addr8)
          ctue_pkg::CTUE_CTRL_OFS: s_d.prdata = {23'h0, s_q.std_sel,
            3'h0, s_q.deferred};
          ctue_pkg::CTUE_DELAY_OFS: s_d.prdata = {22'h0, s_q.delay};
          ctue_pkg::CTUE_GEN_OFS: s_d.prdata = {18'h0, s_q.gen2, 2'h0,
            s_q.gen1};
          ctue_pkg::CTUE_RDR_OFS: s_d.prdata = {18'h0, s_q.rd_end, 2'h0,
            s_q.rd_start};
          ctue_pkg::CTUE_STAT_OFS: s_d.prdata = {16'h0, 2'h0, busy_vec,
            1'h0, eff_std, is_sd, s_q.tc_seen};
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // Frame boundary: latch deferred events, note timecode presence
    if (frame_pulse) begin
      s_d.prev = closed;
      s_d.ann_bits = ann_now;
      s_d.act_bits = act_now;
      s_d.tc_seen = s_q.tc_seen_frame;
      s_d.tc_seen_frame = 1'b0;
      s_d.gen_time = s_q.gen_time + 32'h0000_0001;
    end

    if (tc_in_valid && (!is_sd || in_rd_window)) begin
      // Pass time bits, replace only the user bits
      s_d.tc_seen_frame = 1'b1;
      s_d.tc_out = {tc_in[63:32], ubits};
      s_d.tc_out_valid = 1'b1;
      s_d.tc_out_is_atc = !is_sd;
    end else if (!s_q.tc_seen && (is_sd ? in_gen_line : frame_pulse)) begin
      // Local timecode when nothing arrives, kind per format
      s_d.tc_out = {s_q.gen_time, ubits};
      s_d.tc_out_valid = 1'b1;
      s_d.tc_out_is_atc = !is_sd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.std_sel <= ctue_pkg::CTUE_STD_AUTO;
      s_q.delay <= ctue_pkg::CTUE_DLY_RST;
      s_q.gen1 <= ctue_pkg::CTUE_GEN1_525;
      s_q.gen2 <= ctue_pkg::CTUE_GEN2_525;
      s_q.rd_start <= ctue_pkg::CTUE_RDS_525;
      s_q.rd_end <= ctue_pkg::CTUE_RDE_525;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tc_out = s_q.tc_out;
  assign tc_out_valid = s_q.tc_out_valid;
  assign tc_out_is_atc = s_q.tc_out_is_atc;
endmodule : ctue_encoder

// >>> ctue_enc_properties.sv
// Purpose: Port-level properties of the contact user-bit encoder
// Assumes: One pclk domain, presetn async active low
// Notes: Bound into every encoder instance
`timescale 1ns/1ps
module ctue_enc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic tc_in_valid,
  input wire logic [63:0] tc_in,
  input wire logic [63:0] tc_out,
  input wire logic tc_out_valid,
  input wire logic tc_out_is_atc
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no ready in access phase");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_bad_addr: assert property (
    psel && penable && !pready && paddr > 32'h10 |=> pslverr)
    else $error("unmapped access without error");
  a_time_pass: assert property (
    tc_in_valid && tc_out_is_atc |=> tc_out_valid &&
    tc_out[63:32] == $past(tc_in[63:32]))
    else $error("time bits not passed through");
  a_code_marker: assert property (
    tc_out_valid && tc_out[9:8] == ctue_pkg::CTUE_KIND_IMM &&
    tc_out[5:0] != 6'h00 |-> tc_out[7:6] == 2'b10)
    else $error("contact code lacks marker bit");
  a_kind_legal: assert property (
    tc_out_valid |-> tc_out[9:8] != 2'h3)
    else $error("illegal code kind");
  a_hd_source: assert property (
    tc_out_valid && tc_out_is_atc |-> $past(frame_pulse) || $past(tc_in_valid))
    else $error("ATC word without frame or input");
  a_sd_source: assert property (
    tc_out_valid && !tc_out_is_atc |->
    $past(line_pulse) || $past(line_pulse, 2) || $past(tc_in_valid))
    else $error("VITC word without line or input");
  a_reader_order: assert property (
    rd_ok && paddr == 32'h0C |-> prdata[5:0] <= prdata[13:8])
    else $error("reader start above end");
  a_line_range: assert property (
    rd_ok && paddr == 32'h08 |-> prdata[5:0] inside {[6'h06:6'h20]} &&
    prdata[13:8] inside {[6'h06:6'h20]})
    else $error("generator line out of range");
  a_delay_width: assert property (
    rd_ok && paddr == 32'h04 |-> prdata[31:10] == 22'h0)
    else $error("delay wider than ten bits");
  c_write: cover property (pready && pwrite);
  c_announce: cover property (tc_out_valid && tc_out[9:8] == 2'h1);
  c_act: cover property (tc_out_valid && tc_out[9:8] == 2'h2);
endmodule : ctue_enc_props
bind ctue_encoder ctue_enc_props i_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_pulse(frame_pulse), .line_pulse(line_pulse),
  .tc_in_valid(tc_in_valid), .tc_in(tc_in), .tc_out(tc_out),
  .tc_out_valid(tc_out_valid), .tc_out_is_atc(tc_out_is_atc));

// >>> ctue_dec_model.sv
// Purpose: Downstream user-bit decoder model driving contact outputs
// Assumes: Words arrive as one-cycle valid pulses
// Notes: Countdown ticks on frame_pulse; act word also fires the output
`timescale 1ns/1ps
module ctue_dec_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_pulse,
  input wire logic tc_valid,
  input wire logic [63:0] tc,
  output logic [5:0] contact_output
);
  logic [9:0] cnt_q;
  logic [5:0] pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_output <= 6'h00;
      cnt_q <= 10'h000;
      pend_q <= 6'h00;
    end else if (tc_valid && tc[9:8] == ctue_pkg::CTUE_KIND_IMM) begin
      contact_output <= tc[5:0];
    end else if (tc_valid && tc[9:8] == ctue_pkg::CTUE_KIND_ANN) begin
      cnt_q <= tc[25:16];
      pend_q <= tc[5:0];
    end else if (tc_valid) begin
      // Redundant act word covers a lost announce
      contact_output <= contact_output | tc[5:0];
      pend_q <= 6'h00;
    end else if (frame_pulse && pend_q != 6'h00) begin
      cnt_q <= cnt_q - 10'h001;
      if (cnt_q <= 10'h001) begin
        contact_output <= contact_output | pend_q;
        pend_q <= 6'h00;
      end
    end
  end
endmodule : ctue_dec_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the contact user-bit encoder
// Assumes: APB setup then access phase, one word per register
// Notes: Act word expected exactly delay frames after the announce
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] contact_input_n = 6'h3F;
  logic frame_pulse = 1'b0;
  logic line_pulse = 1'b0;
  logic [5:0] line_number = 6'h00;
  logic [4:0] detected_standard = ctue_pkg::CTUE_STD_525;
  logic tc_in_valid = 1'b0;
  logic [63:0] tc_in = 64'h0;
  logic [63:0] tc_out;
  logic tc_out_valid;
  logic tc_out_is_atc;
  logic [5:0] contact_output;
  logic [63:0] g;
  logic v;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 pclk = ~pclk;
  ctue_encoder i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_input_n(contact_input_n), .frame_pulse(frame_pulse),
    .line_pulse(line_pulse), .line_number(line_number),
    .detected_standard(detected_standard), .tc_in_valid(tc_in_valid),
    .tc_in(tc_in), .tc_out(tc_out), .tc_out_valid(tc_out_valid),
    .tc_out_is_atc(tc_out_is_atc));
  ctue_dec_model i_dec (.pclk(pclk), .presetn(presetn),
    .frame_pulse(frame_pulse), .tc_valid(tc_out_valid), .tc(tc_out),
    .contact_output(contact_output));
  task automatic print_verdict();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic cmpb(input logic exp, input logic got);
    cmp(64'(exp), 64'(got));
  endtask : cmpb
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(64'(x), 64'(r));
    cmpb(xe, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmpb(xe, e);
  endtask : wr
  task automatic wait_tc(input int lim);
    v = 1'b0;
    for (int i = 0; i < lim && !v; i++) begin
      @(posedge pclk);
      tc_in_valid <= 1'b0;
      frame_pulse <= 1'b0;
      v = (tc_out_valid === 1'b1);
      g = tc_out;
    end
  endtask : wait_tc
  task automatic frame();
    @(posedge pclk);
    frame_pulse <= 1'b1;
    wait_tc(4);
  endtask : frame
  task automatic pulse_line(input logic [5:0] ln, input logic tc);
    @(posedge pclk);
    line_pulse <= 1'b1;
    line_number <= ln;
    tc_in_valid <= tc;
    tc_in <= {32'h12345678, 32'hFFFFFFFF};
    @(posedge pclk);
    line_pulse <= 1'b0;
    tc_in_valid <= 1'b0;
    wait_tc(5);
  endtask : pulse_line
  task automatic t_regs();
    rd(32'h00, 32'h0, 1'b0);
    rd(32'h04, 32'h0, 1'b0);
    rd(32'h08, 32'h100E, 1'b0);
    rd(32'h0C, 32'h140A, 1'b0);
    rd(32'h14, 32'h0, 1'b1);
    wr(32'h10, 32'h0, 1'b1);
    wr(32'h04, 32'h3FF, 1'b0);
    rd(32'h04, 32'h3FF, 1'b0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_clamp();
    wr(32'h0C, 32'h0C1E, 1'b0);
    rd(32'h0C, 32'h1E1E, 1'b0);
    wr(32'h08, 32'h2105, 1'b0);
    rd(32'h08, 32'h200A, 1'b0);
    wr(32'h0C, 32'h140A, 1'b0);
    $display("test clamp done");
  endtask : t_clamp
  task automatic t_imm();
    logic [7:0] code [6] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h90, 8'hA0};
    for (int i = 0; i <= 6; i++) begin
      @(posedge pclk);
      contact_input_n <= (i < 6) ? ~6'(1 << i) : 6'h1E;
      pulse_line(6'h0A, 1'b1);
      cmpb(1'b1, v);
      cmp(64'h12345678, 64'(g[63:32]));
      cmp((i < 6) ? 64'(code[i]) : 64'hA1, 64'(g[7:0]));
      cmpb(1'b0, tc_out_is_atc);
    end
    @(posedge pclk);
    contact_input_n <= 6'h3F;
    pulse_line(6'h14, 1'b1);
    cmpb(1'b1, v);
    cmp(64'h0, 64'(g[5:0]));
    pulse_line(6'h15, 1'b1);
    cmpb(1'b0, v);
    pulse_line(6'h09, 1'b1);
    cmpb(1'b0, v);
    $display("test immediate done");
  endtask : t_imm
  task automatic t_gen();
    wr(32'h08, 32'h100E, 1'b0);
    frame();
    frame();
    pulse_line(6'h0E, 1'b0);
    cmpb(1'b1, v);
    pulse_line(6'h0F, 1'b0);
    cmpb(1'b0, v);
    pulse_line(6'h10, 1'b0);
    cmpb(1'b1, v);
    wr(32'h08, 32'h0E0E, 1'b0);
    frame();
    pulse_line(6'h10, 1'b0);
    cmpb(1'b0, v);
    $display("test generate done");
  endtask : t_gen
  task automatic t_hd();
    @(posedge pclk);
    detected_standard <= ctue_pkg::CTUE_STD_1I59;
    frame();
    frame();
    cmpb(1'b1, v);
    cmpb(1'b1, tc_out_is_atc);
    pulse_line(6'h0A, 1'b1);
    cmp(64'h12345678, 64'(g[63:32]));
    wr(32'h00, {23'h0, 5'(ctue_pkg::CTUE_STD_525), 4'h0}, 1'b0);
    frame();
    cmpb(1'b0, v);
    frame();
    pulse_line(6'h0E, 1'b0);
    cmpb(1'b1, v);
    cmpb(1'b0, tc_out_is_atc);
    wr(32'h00, 32'h0, 1'b0);
    $display("test standard done");
  endtask : t_hd
  task automatic t_defer();
    wr(32'h04, 32'h3, 1'b0);
    wr(32'h00, 32'h1, 1'b0);
    frame();
    frame();
    @(posedge pclk);
    contact_input_n <= 6'h3D;
    frame();
    cmp(64'h1, 64'(g[9:8]));
    cmp(64'h3, 64'(g[25:16]));
    cmp(64'h82, 64'(g[7:0]));
    for (int k = 1; k <= 3; k++) begin
      frame();
      cmpb(k == 3, g[9:8] === ctue_pkg::CTUE_KIND_ACT);
    end
    @(posedge pclk);
    cmp(64'h2, 64'(contact_output & 6'h02));
    contact_input_n <= 6'h3F;
    $display("test deferred done");
  endtask : t_defer
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clamp();
    t_imm();
    t_gen();
    t_hd();
    t_defer();
    print_verdict();
  end
endmodule : tb_top
